// [fms_drive_model.sv]
// Behavioural floppy drive: track-zero pins and write pulse counter.
`timescale 1ns/1ps
`default_nettype none
module fms_drive_model (
    // Clock
    input  wire logic ref_clk,
    // Drive pins
    input  wire logic write_data,
    output var logic  trk_norm,
    output var logic  trk_port
);
    int pulses = 0;
    initial begin
        trk_norm = 1'b0;
        trk_port = 1'b0;
    end
    // Pulses last one cycle, so counting high samples counts flux edges.
    always @(posedge ref_clk) begin
        if (write_data) pulses <= pulses + 1;
    end
    task automatic set_track(input logic n, input logic p);
        trk_norm <= n;
        trk_port <= p;
    endtask
endmodule
`default_nettype wire

// [fms_params.svh]
// Constants for the floppy media-ID strap block.
// Operation
// - Sample both media-valid straps while reset is held; use captured values later.
// - Drive 0 accessed, strap captured low: tape register bit 5 reads 0.
// - Drive 0 accessed, strap captured high: tape register bit 5 reads 1.
// - Drive 1 uses the second strap's captured level the same way.
// - First strap's captured level loads function control bit 0 at reset.
// - Function control bit 0 set: strap values carry no media validity meaning.
// - Parallel-port floppy mode with select 0 takes track zero from port pin.
// - Write data leaves serially with software-chosen precompensation applied.
`ifndef FMS_PARAMS_SVH
`define FMS_PARAMS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define FMS_OFF_TAPE      8'h00
`define FMS_OFF_FCR       8'h04
`define FMS_OFF_CTRL      8'h08
`define FMS_OFF_WDATA     8'h0C
`define FMS_OFF_STATUS    8'h10
// ****************************************************************
// Field positions, reset values and serializer timing
// ****************************************************************
`define FMS_TAPE_VALID_BIT 5
`define FMS_FCR_SENSE_BIT  0
`define FMS_CTRL_DRIVE_BIT 0
`define FMS_CTRL_PPM_BIT   1
`define FMS_CTRL_PNF_BIT   2
`define FMS_CTRL_PRE_LSB   4
`define FMS_FCR_RST        32'h0000_0000
`define FMS_CTRL_RST       32'h0000_0004
`define FMS_PRE_STEP_CYC   1
`define FMS_BIT_CYC        8
`endif

// [fms_pkg.sv]
// Types shared by the media-ID strap block.
package fms_pkg;
    typedef enum logic [1:0] {FMS_IDLE, FMS_SHIFT} fms_wr_state_e;
    typedef logic [2:0] fms_pre_t;
endpackage

// [fms_strap_top.sv]
// Media-ID strap capture, track-zero select and register slave.
`timescale 1ns/1ps
`default_nettype none
`include "fms_params.svh"
module fms_strap_top (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    // Strap pins
    input  wire logic         media_valid_strap_drive0,
    input  wire logic         media_valid_strap_drive1,
    // Drive pins
    input  wire logic         track_zero_input,
    input  wire logic         track_zero_port_input,
    output var logic          track_zero,
    output var logic          write_data,
    // AXI4-Lite write
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output var logic          s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output var logic          s_axi_wready,
    output var logic [1:0]    s_axi_bresp,
    output var logic          s_axi_bvalid,
    input  wire logic         s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output var logic          s_axi_arready,
    output var logic [31:0]   s_axi_rdata,
    output var logic [1:0]    s_axi_rresp,
    output var logic          s_axi_rvalid,
    input  wire logic         s_axi_rready
);
    import fms_pkg::*;
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // No reset here: the straps must pass through while reset is held.
    logic [3:0] s1_ff, s2_ff;
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            s1_ff <= {track_zero_port_input, track_zero_input,
                      media_valid_strap_drive1, media_valid_strap_drive0};
            s2_ff <= s1_ff;
        end
    end
    // ************************************************************
    // Strap capture
    // ************************************************************
    // Sampling runs while reset is held, so it is a synchronous path
    // off the reset; the asynchronous branch would only load constants.
    logic [1:0] strap_ff, nxt_strap;
    logic       fcr_ff,   nxt_fcr;
    logic       rst_q_ff;
    logic       aw_ff, nxt_aw, w_ff, nxt_w;
    logic [7:0] awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd;
    logic [3:0] ws_ff,  nxt_ws;
    logic       b_ff, nxt_b, r_ff, nxt_r;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rd_ff, nxt_rd;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic       wok;
    fms_wr_if   wrif ();
    // Straps are sampled from the synchronised copy while reset is held and
    // for one cycle after, so a pin that settles late is still caught.
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            rst_q_ff <= rst;
            if (rst || rst_q_ff) begin
                strap_ff <= s2_ff[1:0];
                fcr_ff   <= s2_ff[0];
            end else begin
                strap_ff <= nxt_strap;
                fcr_ff   <= nxt_fcr;
            end
        end
    end
    // Register decode used by both read and write paths.
    function automatic logic [2:0] fms_dec(input logic [7:0] a);
        case (a)
            `FMS_OFF_TAPE:   fms_dec = 3'h1;
            `FMS_OFF_FCR:    fms_dec = 3'h2;
            `FMS_OFF_CTRL:   fms_dec = 3'h3;
            `FMS_OFF_WDATA:  fms_dec = 3'h4;
            `FMS_OFF_STATUS: fms_dec = 3'h5;
            default:         fms_dec = 3'h0;
        endcase
    endfunction
    logic       drv_sel;
    logic       vbit;
    // ************************************************************
    // Register file and bus slave
    // ************************************************************
    always_comb begin
        drv_sel   = ctrl_ff[`FMS_CTRL_DRIVE_BIT];
        // Valid bit mirrors the accessed drive's strap; meaningless when
        // the function control bit selects data-rate signalling.
        vbit      = fcr_ff ? 1'b1 : strap_ff[drv_sel];
        nxt_strap = strap_ff;
        nxt_fcr   = fcr_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_aw    = aw_ff;
        nxt_awa   = awa_ff;
        nxt_w     = w_ff;
        nxt_wd    = wd_ff;
        nxt_ws    = ws_ff;
        nxt_b     = b_ff;
        nxt_bresp = bresp_ff;
        nxt_r     = r_ff;
        nxt_rresp = rresp_ff;
        nxt_rd    = rd_ff;
        wrif.start = 1'b0;
        wrif.data  = wd_ff[7:0];
        wok        = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw  = 1'b1;
            nxt_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w  = 1'b1;
            nxt_wd = s_axi_wdata;
            nxt_ws = s_axi_wstrb;
        end
        if (aw_ff && w_ff && !b_ff) begin
            nxt_aw    = 1'b0;
            nxt_w     = 1'b0;
            nxt_b     = 1'b1;
            nxt_bresp = 2'b00;
            case (fms_dec(awa_ff))
                3'h2: if (ws_ff[0]) nxt_fcr = wd_ff[`FMS_FCR_SENSE_BIT];
                3'h3: if (ws_ff[0]) nxt_ctrl = {24'h0, wd_ff[7:0]};
                3'h4: begin
                    wok        = ws_ff[0] && !wrif.busy;
                    wrif.start = wok;
                    if (!wok) nxt_bresp = 2'b10;
                end
                3'h1, 3'h5: nxt_bresp = 2'b00;
                default: nxt_bresp = 2'b10;
            endcase
        end
        if (b_ff && s_axi_bready) nxt_b = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_r     = 1'b1;
            nxt_rresp = 2'b00;
            case (fms_dec(s_axi_araddr))
                3'h1: nxt_rd = 32'(vbit) << `FMS_TAPE_VALID_BIT;
                3'h2: nxt_rd = {31'h0, fcr_ff};
                3'h3: nxt_rd = ctrl_ff;
                3'h4: nxt_rd = {24'h0, wd_ff[7:0]};
                3'h5: nxt_rd = {29'h0, wrif.busy, strap_ff};
                default: begin
                    nxt_rd    = 32'h0;
                    nxt_rresp = 2'b10;
                end
            endcase
        end
        if (r_ff && s_axi_rready) nxt_r = 1'b0;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff  <= `FMS_CTRL_RST;
            aw_ff    <= 1'b0;
            awa_ff   <= 8'h00;
            w_ff     <= 1'b0;
            wd_ff    <= 32'h0;
            ws_ff    <= 4'h0;
            b_ff     <= 1'b0;
            bresp_ff <= 2'b00;
            r_ff     <= 1'b0;
            rresp_ff <= 2'b00;
            rd_ff    <= 32'h0;
        end else if (clk_en) begin
            ctrl_ff  <= nxt_ctrl;
            aw_ff    <= nxt_aw;
            awa_ff   <= nxt_awa;
            w_ff     <= nxt_w;
            wd_ff    <= nxt_wd;
            ws_ff    <= nxt_ws;
            b_ff     <= nxt_b;
            bresp_ff <= nxt_bresp;
            r_ff     <= nxt_r;
            rresp_ff <= nxt_rresp;
            rd_ff    <= nxt_rd;
        end
    end
    assign s_axi_awready = clk_en && !aw_ff && !b_ff;
    assign s_axi_wready  = clk_en && !w_ff && !b_ff;
    assign s_axi_bvalid  = b_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = clk_en && !r_ff;
    assign s_axi_rvalid  = r_ff;
    assign s_axi_rresp   = rresp_ff;
    assign s_axi_rdata   = rd_ff;
    assign wrif.pre = ctrl_ff[`FMS_CTRL_PRE_LSB +: 3];
    // ************************************************************
    // Track zero and write data
    // ************************************************************
    always_comb begin
        if (ctrl_ff[`FMS_CTRL_PPM_BIT] && !ctrl_ff[`FMS_CTRL_PNF_BIT]) begin
            track_zero = s2_ff[3];
        end else begin
            track_zero = s2_ff[2];
        end
    end
    fms_wr_ser u_ser (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .wr         (wrif.ser),
        .write_data (write_data)
    );
endmodule
`default_nettype wire

// [fms_strap_top_properties.sv]
// Concurrent checks on the strap block's ports.
`timescale 1ns/1ps
`default_nettype none
module fms_strap_props (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Drive pins
    input wire logic       track_zero_input,
    input wire logic       track_zero_port_input,
    input wire logic       track_zero,
    input wire logic       write_data,
    // Register bus
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10;
    endsequence
    // Both pins agreeing means the result cannot depend on the mode.
    sequence pins_agree;
        track_zero_input == track_zero_port_input && $stable(track_zero_input);
    endsequence
    AST_TRK_FOLLOWS: assert property (
        pins_agree [*3] |-> track_zero == track_zero_input)
        else $error("track zero does not follow agreeing pins");
    AST_WD_PULSE: assert property (write_data |=> !write_data)
        else $error("write data pulse longer than one cycle");
    AST_B_AFTER_WR: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("no write response");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_B_BLOCKS: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    AST_R_UNMAPPED: assert property (
        rd_unmapped |-> ##[1:2] s_axi_rvalid && s_axi_rresp == 2'b10)
        else $error("unmapped read not refused");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
        else $error("read response dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
endmodule
bind fms_strap_top fms_strap_props u_props (.ref_clk, .rst, .track_zero_input,
    .track_zero_port_input, .track_zero, .write_data, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
`default_nettype wire

// [fms_strap_top_tb.sv]
// Self-checking bench for the media-ID strap block.
`timescale 1ns/1ps
`default_nettype none
`include "fms_params.svh"
module fms_strap_top_tb;
    logic        ref_clk = 1'b0, rst = 1'b1, s0 = 1'b0, s1 = 1'b0;
    logic        trk_n, trk_p, trk, wd, awready, wready, bvalid;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    int          err_total = 0, checks = 0;
    fms_strap_top DUT (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
        .media_valid_strap_drive0(s0), .media_valid_strap_drive1(s1),
        .track_zero_input(trk_n), .track_zero_port_input(trk_p),
        .track_zero(trk), .write_data(wd), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    fms_drive_model drv (.ref_clk(ref_clk), .write_data(wd),
        .trk_norm(trk_n), .trk_port(trk_p));
    initial forever #25 ref_clk = ~ref_clk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Each request waits for its answer; only the watchdog ends a hang.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic ap, wp;
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        ap = 1'b1;
        wp = 1'b1;
        do begin
            @(posedge ref_clk);
            if (ap && awready) begin
                awvalid <= 1'b0;
                ap = 1'b0;
            end
            if (wp && wready) begin
                wvalid <= 1'b0;
                wp = 1'b0;
            end
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_strap(input logic v0, input logic v1);
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge ref_clk);
        rst <= 1'b1;
        s0 <= v0;
        s1 <= v1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd(8'h04, d, r);
        cmp(d & 32'h1, {31'h0, v0});
        wr(8'h04, 32'h0, r);
        wr(8'h08, 32'h4, r);
        rd(8'h00, d, r);
        cmp({31'h0, d[5]}, {31'h0, v0});
        wr(8'h08, 32'h5, r);
        rd(8'h00, d, r);
        cmp({31'h0, d[5]}, {31'h0, v1});
        wr(8'h04, 32'h1, r);
        rd(8'h00, d, r);
        cmp({31'h0, d[5]}, 32'h1);
        s0 <= ~v0;
        s1 <= ~v1;
        repeat (4) @(posedge ref_clk);
        rd(8'h10, d, r);
        cmp(d & 32'h3, {30'h0, v1, v0});
        $display("strap test done");
    endtask
    task automatic t_track();
        logic [1:0] r;
        drv.set_track(1'b1, 1'b0);
        repeat (4) @(negedge ref_clk);
        cmp({31'h0, trk}, 32'h1);
        wr(8'h08, 32'h2, r);
        repeat (4) @(negedge ref_clk);
        cmp({31'h0, trk}, 32'h0);
        drv.set_track(1'b0, 1'b1);
        repeat (4) @(negedge ref_clk);
        cmp({31'h0, trk}, 32'h1);
        $display("track test done");
    endtask
    task automatic t_write();
        logic [31:0] d;
        logic [1:0]  r;
        int          n0, c0, c1;
        // Same bus timing twice, so only the setting moves the first pulse.
        n0 = drv.pulses;
        wr(8'h08, 32'h04, r);
        wr(8'h0C, 32'h80, r);
        c0 = 0;
        while (drv.pulses == n0) begin
            @(posedge ref_clk);
            c0++;
        end
        repeat (70) @(posedge ref_clk);
        n0 = drv.pulses;
        wr(8'h08, 32'h24, r);
        wr(8'h0C, 32'hA5, r);
        cmp({30'h0, r}, 32'h0);
        c1 = 0;
        while (drv.pulses == n0) begin
            @(posedge ref_clk);
            c1++;
        end
        cmp(32'(c1 - c0), 32'(2 * `FMS_PRE_STEP_CYC));
        wr(8'h0C, 32'hFF, r);
        cmp({30'h0, r}, 32'h2);
        repeat (90) @(posedge ref_clk);
        cmp(32'(drv.pulses - n0), 32'h4);
        rd(8'h20, d, r);
        cmp({30'h0, r}, 32'h2);
        $display("write test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        close_out();
    end
    initial begin
        t_strap(1'b1, 1'b0);
        t_strap(1'b0, 1'b1);
        t_track();
        t_write();
        close_out();
    end
endmodule
`default_nettype wire

// [fms_wr_if.sv]
// Interface between the register block and the write serializer.
`timescale 1ns/1ps
`default_nettype none
interface fms_wr_if;
    logic              start;
    logic [7:0]        data;
    fms_pkg::fms_pre_t pre;
    logic              busy;
    modport ctl (output start, output data, output pre, input busy);
    modport ser (input start, input data, input pre, output busy);
endinterface
`default_nettype wire

// [fms_wr_ser.sv]
// Serializer for precompensated floppy write data.
`timescale 1ns/1ps
`default_nettype none
`include "fms_params.svh"
module fms_wr_ser (
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rst,
    input  wire logic  clk_en,
    // Control
    fms_wr_if.ser      wr,
    // Drive pin
    output var logic   write_data
);
    import fms_pkg::*;
    fms_wr_state_e state_ff,  nxt_state;
    logic [7:0]    shreg_ff,  nxt_shreg;
    logic [2:0]    bitn_ff,   nxt_bitn;
    logic [3:0]    cyc_ff,    nxt_cyc;
    logic          wd_ff,     nxt_wd;
    logic [3:0]    pulse_at;
    // Precompensation shifts the pulse inside its bit cell by the setting.
    always_comb begin
        pulse_at  = 4'(wr.pre) * 4'(`FMS_PRE_STEP_CYC);
        nxt_state = state_ff;
        nxt_shreg = shreg_ff;
        nxt_bitn  = bitn_ff;
        nxt_cyc   = cyc_ff;
        nxt_wd    = 1'b0;
        case (state_ff)
            FMS_IDLE: begin
                if (wr.start) begin
                    nxt_state = FMS_SHIFT;
                    nxt_shreg = wr.data;
                    nxt_bitn  = 3'h0;
                    nxt_cyc   = 4'h0;
                end
            end
            FMS_SHIFT: begin
                nxt_wd  = shreg_ff[7] && (cyc_ff == pulse_at);
                nxt_cyc = cyc_ff + 4'h1;
                if (cyc_ff == 4'(`FMS_BIT_CYC - 1)) begin
                    nxt_cyc   = 4'h0;
                    nxt_shreg = {shreg_ff[6:0], 1'b0};
                    nxt_bitn  = bitn_ff + 3'h1;
                    if (bitn_ff == 3'h7) begin
                        nxt_state = FMS_IDLE;
                    end
                end
            end
            default: nxt_state = FMS_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= FMS_IDLE;
            shreg_ff <= 8'h00;
            bitn_ff  <= 3'h0;
            cyc_ff   <= 4'h0;
            wd_ff    <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            shreg_ff <= nxt_shreg;
            bitn_ff  <= nxt_bitn;
            cyc_ff   <= nxt_cyc;
            wd_ff    <= nxt_wd;
        end
    end
    assign wr.busy    = (state_ff == FMS_SHIFT);
    assign write_data = wd_ff;
endmodule
`default_nettype wire
